// >>> hw/aqr_pkg.sv
// constants shared by the ascii query responder
package aqr_pkg;
	localparam int unsigned CLK_HZ     = 25000000;
	localparam int unsigned BAUD_RATE  = 300;
	localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE;
	localparam int unsigned CNT_W      = 17;

	localparam logic [7:0] CH_CR    = 8'h0D;
	localparam logic [7:0] CH_LF    = 8'h0A;
	localparam logic [7:0] CH_EQ    = 8'h3D;
	localparam logic [7:0] CH_PLUS  = 8'h2B;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_DOT   = 8'h2E;
	localparam logic [7:0] CH_ZERO  = 8'h30;
	localparam logic [7:0] CH_CLOSE = 8'h21;
	localparam logic [7:0] CH_SPACE = 8'h20;

	localparam logic [7:0] CODE_D = 8'h44;
	localparam logic [7:0] CODE_E = 8'h45;
	localparam logic [7:0] CODE_I = 8'h49;
	localparam logic [7:0] CODE_L = 8'h4C;
	localparam logic [7:0] CODE_P = 8'h50;
	localparam logic [7:0] CODE_S = 8'h53;
	localparam logic [7:0] CODE_T = 8'h54;
	localparam logic [7:0] CODE_V = 8'h56;

	localparam logic [7:0] UNIT_C = 8'h43;
	localparam logic [7:0] UNIT_A = 8'h41;
	localparam logic [7:0] UNIT_V = 8'h56;
	localparam logic [7:0] UNIT_W = 8'h57;

	localparam int unsigned RESP_LEN  = 14;
	localparam logic [3:0]  RESP_LAST = 4'hD;
	localparam int unsigned FRAME_BITS = 10;
	localparam logic [3:0]  FRAME_LAST = 4'h9;
	localparam logic [2:0]  DATA_LAST  = 3'h7;

	// battery voltage in tenths of a volt; 65.0 V
	localparam logic [15:0] OV_THRESH_DV = 16'h028A;
	localparam logic [1:0]  SETTLE_LAST  = 2'h3;
	localparam logic [1:0]  BUF_DEPTH    = 2'h2;

	typedef enum logic [3:0] {
		AQR_RX_IDLE  = 4'h1,
		AQR_RX_START = 4'h2,
		AQR_RX_DATA  = 4'h4,
		AQR_RX_STOP  = 4'h8
	} aqr_rx_t;

	typedef enum logic [3:0] {
		AQR_P_CR   = 4'h1,
		AQR_P_LF   = 4'h2,
		AQR_P_CODE = 4'h4,
		AQR_P_ADDR = 4'h8
	} aqr_parse_t;

	typedef enum logic [2:0] {
		AQR_M_IDLE  = 3'h1,
		AQR_M_FETCH = 3'h2,
		AQR_M_SEND  = 3'h4
	} aqr_main_t;

	function automatic logic [7:0] aqr_unit(input logic [7:0] code);
		case (code)
			CODE_D, CODE_T:         aqr_unit = UNIT_C;
			CODE_I:                 aqr_unit = UNIT_A;
			CODE_P:                 aqr_unit = UNIT_W;
			CODE_L, CODE_S, CODE_V: aqr_unit = UNIT_V;
			default:                aqr_unit = CH_SPACE;
		endcase
	endfunction

	function automatic logic aqr_known(input logic [7:0] code);
		case (code)
			CODE_D, CODE_E, CODE_I, CODE_L, CODE_P, CODE_S, CODE_T, CODE_V:
				aqr_known = 1'b1;
			default:
				aqr_known = 1'b0;
		endcase
	endfunction
endpackage

// >>> hw/aqr_responder.sv
// ascii measured-value query responder on the open-collector chain bus
`timescale 1ns/10ps
module aqr_responder #(
	parameter int unsigned BIT_CYCLES = aqr_pkg::BIT_CYCLES
) (
	input  wire logic        clk,                 // 25 MHz clock
	input  wire logic        rst_b,               // async reset, active low
	input  wire logic        chain_query_bus_in,  // bus line level (pin)
	output logic             chain_query_bus_out, // driven level, always low
	output logic             chain_query_bus_oe,  // high while pulling low
	input  wire logic        address_switch_bit0, // address switch, lsb
	input  wire logic        address_switch_bit1, // address switch
	input  wire logic        address_switch_bit2, // address switch, msb
	input  wire logic        standalone_mode,     // stand-alone mode switch (pin)
	input  wire logic        temp_input_open,     // temperature input open (pin)
	output logic             run_enable,          // device may operate
	input  wire logic [15:0] batt_voltage_dv,     // battery voltage, 0.1 V units
	output logic             signal_contact,      // contact closed when high
	output logic             meas_req,            // value request, level until ack
	output logic [7:0]       meas_code,           // requested code letter
	input  wire logic        meas_ack,            // value valid, one cycle
	input  wire logic        meas_negative,       // value is negative
	input  wire logic [19:0] meas_bcd             // four integer digits, one fraction
);
	localparam logic [aqr_pkg::CNT_W-1:0] FULL = aqr_pkg::CNT_W'(BIT_CYCLES - 1);
	localparam logic [aqr_pkg::CNT_W-1:0] HALF = aqr_pkg::CNT_W'(BIT_CYCLES / 2);

	// two-stage synchronisers for every pin input
	logic [5:0] sync1_reg;
	logic [5:0] sync2_reg;
	wire  [5:0] pins = {temp_input_open, standalone_mode, address_switch_bit2,
		address_switch_bit1, address_switch_bit0, chain_query_bus_in};
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			sync1_reg <= 6'h01;
			sync2_reg <= 6'h01;
		end
		else
		begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
		end
	wire       rx_line   = sync2_reg[0];
	wire [2:0] own_addr  = sync2_reg[3:1];
	wire       sa_mode   = sync2_reg[4];
	wire       temp_open = sync2_reg[5];

	// start-up inhibit
	logic [1:0] settle_reg;
	logic       run_reg;
	wire        start_ok = !(sa_mode && temp_open);
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			settle_reg <= 2'h0;
			run_reg    <= 1'b0;
		end
		else
		begin
			if (settle_reg != aqr_pkg::SETTLE_LAST)
				settle_reg <= settle_reg + 2'h1;
			else if (start_ok)
				run_reg <= 1'b1;
		end
	assign run_enable = run_reg;

	// overvoltage contact
	logic contact_reg;
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			contact_reg <= 1'b0;
		else
			contact_reg <= batt_voltage_dv > aqr_pkg::OV_THRESH_DV;
	assign signal_contact = contact_reg;

	// byte receiver, 8N1, sampled mid-bit
	aqr_pkg::aqr_rx_t           rx_state_reg;
	logic [aqr_pkg::CNT_W-1:0]  rx_cnt_reg;
	logic [2:0]                 rx_bit_reg;
	logic [7:0]                 rx_shift_reg;
	logic                       rx_valid_reg;
	wire                        rx_tick = (rx_cnt_reg == '0);
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			rx_state_reg <= aqr_pkg::AQR_RX_IDLE;
			rx_cnt_reg   <= '0;
			rx_bit_reg   <= 3'h0;
			rx_shift_reg <= 8'h00;
			rx_valid_reg <= 1'b0;
		end
		else
		begin
			rx_valid_reg <= 1'b0;
			if (rx_state_reg != aqr_pkg::AQR_RX_IDLE)
				rx_cnt_reg <= rx_tick ? FULL : rx_cnt_reg - 1'b1;
			case (rx_state_reg)
				aqr_pkg::AQR_RX_IDLE:
					if (!rx_line)
					begin
						rx_cnt_reg   <= HALF;
						rx_state_reg <= aqr_pkg::AQR_RX_START;
					end
				aqr_pkg::AQR_RX_START:
					if (rx_tick)
					begin
						rx_bit_reg   <= 3'h0;
						rx_state_reg <= rx_line ? aqr_pkg::AQR_RX_IDLE : aqr_pkg::AQR_RX_DATA;
					end
				aqr_pkg::AQR_RX_DATA:
					if (rx_tick)
					begin
						rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
						rx_bit_reg   <= rx_bit_reg + 3'h1;
						if (rx_bit_reg == aqr_pkg::DATA_LAST)
							rx_state_reg <= aqr_pkg::AQR_RX_STOP;
					end
				aqr_pkg::AQR_RX_STOP:
					if (rx_tick)
					begin
						rx_valid_reg <= rx_line;
						rx_state_reg <= aqr_pkg::AQR_RX_IDLE;
					end
				default:
					rx_state_reg <= aqr_pkg::AQR_RX_IDLE;
			endcase
		end

	// request parser and reply sequencer
	aqr_pkg::aqr_parse_t p_state_reg;
	aqr_pkg::aqr_main_t  m_state_reg;
	logic [7:0]          code_reg;
	logic [7:0]          code_seen_reg;
	logic                neg_reg;
	logic [19:0]         bcd_reg;
	logic [3:0]          idx_reg;
	wire                 idle      = (m_state_reg == aqr_pkg::AQR_M_IDLE);
	wire                 take_byte = rx_valid_reg && idle;
	wire [7:0]           addr_char = aqr_pkg::CH_ZERO + {5'h00, own_addr};
	wire                 addr_hit  = (rx_shift_reg == addr_char);
	wire                 is_cr     = (rx_shift_reg == aqr_pkg::CH_CR);
	wire                 push_rdy;
	wire                 push_val  = (m_state_reg == aqr_pkg::AQR_M_SEND);

	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			p_state_reg <= aqr_pkg::AQR_P_CR;
		else if (take_byte)
			case (p_state_reg)
				aqr_pkg::AQR_P_CR:
					p_state_reg <= is_cr ? aqr_pkg::AQR_P_LF : aqr_pkg::AQR_P_CR;
				aqr_pkg::AQR_P_LF:
					p_state_reg <= (rx_shift_reg == aqr_pkg::CH_LF) ? aqr_pkg::AQR_P_CODE
						: is_cr ? aqr_pkg::AQR_P_LF : aqr_pkg::AQR_P_CR;
				aqr_pkg::AQR_P_CODE:
					p_state_reg <= aqr_pkg::aqr_known(rx_shift_reg) ? aqr_pkg::AQR_P_ADDR
						: is_cr ? aqr_pkg::AQR_P_LF : aqr_pkg::AQR_P_CR;
				default:
					p_state_reg <= is_cr ? aqr_pkg::AQR_P_LF : aqr_pkg::AQR_P_CR;
			endcase

	wire req_done = take_byte && (p_state_reg == aqr_pkg::AQR_P_ADDR) && addr_hit;

	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			m_state_reg   <= aqr_pkg::AQR_M_IDLE;
			code_reg      <= 8'h00;
			code_seen_reg <= 8'h00;
			neg_reg       <= 1'b0;
			bcd_reg       <= 20'h00000;
			idx_reg       <= 4'h0;
		end
		else
			case (m_state_reg)
				aqr_pkg::AQR_M_IDLE:
				begin
					if (take_byte && p_state_reg == aqr_pkg::AQR_P_CODE)
						code_seen_reg <= rx_shift_reg;
					if (req_done)
					begin
						code_reg    <= code_seen_reg;
						m_state_reg <= aqr_pkg::AQR_M_FETCH;
					end
				end
				aqr_pkg::AQR_M_FETCH:
					if (meas_ack)
					begin
						neg_reg     <= meas_negative;
						bcd_reg     <= meas_bcd;
						idx_reg     <= 4'h0;
						m_state_reg <= aqr_pkg::AQR_M_SEND;
					end
				aqr_pkg::AQR_M_SEND:
					if (push_rdy)
					begin
						idx_reg <= idx_reg + 4'h1;
						if (idx_reg == aqr_pkg::RESP_LAST)
							m_state_reg <= aqr_pkg::AQR_M_IDLE;
					end
				default:
					m_state_reg <= aqr_pkg::AQR_M_IDLE;
			endcase
	assign meas_req  = (m_state_reg == aqr_pkg::AQR_M_FETCH);
	assign meas_code = code_reg;

	// reply characters by position
	wire [7:0] resp_char [aqr_pkg::RESP_LEN];
	assign resp_char[0]  = aqr_pkg::CH_CR;
	assign resp_char[1]  = aqr_pkg::CH_LF;
	assign resp_char[2]  = code_reg;
	assign resp_char[3]  = addr_char;
	assign resp_char[4]  = aqr_pkg::CH_EQ;
	assign resp_char[5]  = neg_reg ? aqr_pkg::CH_MINUS : aqr_pkg::CH_PLUS;
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_int
			assign resp_char[6+g] = aqr_pkg::CH_ZERO + {4'h0, bcd_reg[19-4*g -: 4]};
		end
	endgenerate
	assign resp_char[10] = aqr_pkg::CH_DOT;
	assign resp_char[11] = aqr_pkg::CH_ZERO + {4'h0, bcd_reg[3:0]};
	assign resp_char[12] = aqr_pkg::aqr_unit(code_reg);
	assign resp_char[13] = aqr_pkg::CH_CLOSE;
	wire [7:0] push_data = resp_char[idx_reg];

	// two-entry buffer between sequencer and transmitter
	logic [7:0] buf_mem [2];
	logic       wr_ptr_reg;
	logic       rd_ptr_reg;
	logic [1:0] count_reg;
	wire        pop_rdy;
	wire        pop_val = (count_reg != 2'h0);
	assign push_rdy = (count_reg != aqr_pkg::BUF_DEPTH);
	wire        do_push = push_val && push_rdy;
	wire        do_pop  = pop_val && pop_rdy;
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			buf_mem[0] <= 8'h00;
			buf_mem[1] <= 8'h00;
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end
		else
		begin
			if (do_push)
			begin
				buf_mem[wr_ptr_reg] <= push_data;
				wr_ptr_reg          <= !wr_ptr_reg;
			end
			if (do_pop)
				rd_ptr_reg <= !rd_ptr_reg;
			count_reg <= count_reg + {1'b0, do_push} - {1'b0, do_pop};
		end

	// byte transmitter; the line is only ever pulled low or released
	logic                      tx_busy_reg;
	logic [aqr_pkg::CNT_W-1:0] tx_cnt_reg;
	logic [3:0]                tx_n_reg;
	logic [9:0]                tx_shift_reg;
	logic                      tx_pull_reg;
	assign pop_rdy = !tx_busy_reg;
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			tx_busy_reg  <= 1'b0;
			tx_cnt_reg   <= '0;
			tx_n_reg     <= 4'h0;
			tx_shift_reg <= 10'h3FF;
			tx_pull_reg  <= 1'b0;
		end
		else if (!tx_busy_reg)
		begin
			tx_pull_reg <= 1'b0;
			if (do_pop)
			begin
				tx_busy_reg  <= 1'b1;
				tx_shift_reg <= {1'b1, buf_mem[rd_ptr_reg], 1'b0};
				tx_cnt_reg   <= FULL;
				tx_n_reg     <= 4'h0;
				tx_pull_reg  <= 1'b1;
			end
		end
		else if (tx_cnt_reg != '0)
			tx_cnt_reg <= tx_cnt_reg - 1'b1;
		else if (tx_n_reg == aqr_pkg::FRAME_LAST)
		begin
			tx_busy_reg <= 1'b0;
			tx_pull_reg <= 1'b0;
		end
		else
		begin
			tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
			tx_pull_reg  <= !tx_shift_reg[1];
			tx_n_reg     <= tx_n_reg + 4'h1;
			tx_cnt_reg   <= FULL;
		end
	assign chain_query_bus_out = 1'b0;
	assign chain_query_bus_oe  = tx_pull_reg;
endmodule

// >>> test/aqr_responder_chk.sv
// port assertions for the ascii query responder
`timescale 1ns/10ps
module aqr_responder_chk #(
	parameter int unsigned BIT_CYCLES = 16
) (
	input wire logic        clk,                 // clock
	input wire logic        rst_b,               // reset, active low
	input wire logic        chain_query_bus_out, // driven level
	input wire logic        chain_query_bus_oe,  // pull-low enable
	input wire logic        standalone_mode,     // mode pin
	input wire logic        temp_input_open,     // open sensor pin
	input wire logic        run_enable,          // may operate
	input wire logic [15:0] batt_voltage_dv,     // battery voltage
	input wire logic        signal_contact,      // contact closed
	input wire logic        meas_req,            // value request
	input wire logic [7:0]  meas_code,           // requested code
	input wire logic        meas_ack             // value valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic [15:0] run_reg;
	// length of the current pulled-low stretch
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			run_reg <= 16'h0000;
		else
			run_reg <= chain_query_bus_oe ? run_reg + 16'h0001 : 16'h0000;
	end
	sequence s_ack;
		meas_req && meas_ack;
	endsequence
	sequence s_inhibit;
		(standalone_mode && temp_input_open) [*8];
	endsequence
	chk_drive_low: assert property (chain_query_bus_out == 1'b0)
		else $error("bus data level not low");
	chk_bit_length: assert property ($fell(chain_query_bus_oe) |-> run_reg % BIT_CYCLES == 0)
		else $error("low stretch not whole bits");
	chk_contact_on: assert property (batt_voltage_dv > 16'h028A |=> signal_contact)
		else $error("contact open at overvoltage");
	chk_contact_off: assert property (batt_voltage_dv <= 16'h028A |=> !signal_contact)
		else $error("contact closed without overvoltage");
	chk_code_held: assert property (meas_req && !meas_ack |=> meas_req && $stable(meas_code))
		else $error("request dropped or code changed");
	chk_code_known: assert property (meas_req |-> meas_code inside {8'h44, 8'h45, 8'h49,
		8'h4C, 8'h50, 8'h53, 8'h54, 8'h56})
		else $error("unknown code requested");
	chk_reply_start: assert property (s_ack |=> !meas_req ##[0:3] chain_query_bus_oe)
		else $error("reply did not start");
	chk_silent_fetch: assert property (meas_req |-> !chain_query_bus_oe)
		else $error("bus pulled while fetching");
	chk_run_inhibit: assert property (s_inhibit |-> !$rose(run_enable))
		else $error("started with open sensor input");
endmodule
bind aqr_responder aqr_responder_chk #(.BIT_CYCLES(BIT_CYCLES)) u_chk (.clk, .rst_b,
	.chain_query_bus_out, .chain_query_bus_oe, .standalone_mode, .temp_input_open,
	.run_enable, .batt_voltage_dv, .signal_contact, .meas_req, .meas_code, .meas_ack);

// >>> test/aqr_master_model.sv
// chain bus master: sends request bytes, collects reply bytes
`timescale 1ns/10ps
module aqr_master_model #(
	parameter int BITC = 16
) (
	input  wire logic clk,       // bench clock
	input  wire logic bus_level, // resolved line
	output logic      oe         // high while pulling low
);
	logic [7:0] rx_q[$];
	logic [7:0] rx_byte;
	logic       tx_busy = 1'b0;
	initial oe = 1'b0;
	// one 8N1 frame, lsb first
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		tx_busy = 1'b1;
		@(posedge clk);
		#1;
		for (int i = 0; i < 10; i++)
		begin
			oe = !f[i];
			// the stop bit is released, so a reply may start before it ends
			tx_busy = (i < 9);
			repeat (BITC) @(posedge clk);
			#1;
		end
	endtask
	// own frames are not collected
	always
	begin
		@(negedge bus_level);
		if (!tx_busy)
		begin
			repeat (BITC / 2) @(posedge clk);
			for (int j = 0; j < 8; j++)
			begin
				repeat (BITC) @(posedge clk);
				rx_byte[j] = bus_level;
			end
			repeat (BITC) @(posedge clk);
			if (bus_level)
				rx_q.push_back(rx_byte);
		end
	end
endmodule

// >>> test/testbench.sv
// self-checking bench for the ascii query responder
`timescale 1ns/10ps
module testbench;
	localparam int BITC = 16;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        dut_oe;
	logic        m_oe;
	wire         bus_level;
	logic [2:0]  sw = 3'h0;
	logic        sa = 1'b0;
	logic        topen = 1'b0;
	logic        run_en;
	logic [15:0] batt = 16'h0000;
	logic        contact;
	logic        req;
	logic [7:0]  code;
	logic        ack = 1'b0;
	logic        neg = 1'b0;
	logic [19:0] bcd = 20'h00000;
	int          dly = 0;
	logic [7:0]  exp_code = 8'h00;
	int          cycles = 0;
	int          num_errors = 0;
	int          cmp_count = 0;
	logic [7:0]  codes[8] = '{8'h44, 8'h45, 8'h49, 8'h4C, 8'h50, 8'h53, 8'h54, 8'h56};
	logic [7:0]  units[8] = '{8'h43, 8'h20, 8'h41, 8'h56, 8'h57, 8'h56, 8'h43, 8'h56};
	assign bus_level = !(dut_oe || m_oe);
	aqr_responder #(.BIT_CYCLES(BITC)) u_dut (.clk(clk), .rst_b(rst_b),
		.chain_query_bus_in(bus_level), .chain_query_bus_out(), .chain_query_bus_oe(dut_oe),
		.address_switch_bit0(sw[0]), .address_switch_bit1(sw[1]), .address_switch_bit2(sw[2]),
		.standalone_mode(sa), .temp_input_open(topen), .run_enable(run_en),
		.batt_voltage_dv(batt), .signal_contact(contact), .meas_req(req), .meas_code(code),
		.meas_ack(ack), .meas_negative(neg), .meas_bcd(bcd));
	aqr_master_model #(.BITC(BITC)) u_master (.clk(clk), .bus_level(bus_level), .oe(m_oe));
	always #20 clk = !clk;
	task automatic tick(input int n);
		if (n > 0)
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask
	// value source: one-cycle ack after dly cycles
	always
	begin
		tick(1);
		if (req === 1'b1)
		begin
			cmp(code, exp_code);
			tick(dly);
			ack = 1'b1;
			tick(1);
			ack = 1'b0;
		end
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			num_errors++;
			give_verdict();
		end
	end
	task give_verdict;
		if (num_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic send4(input logic [7:0] c, input logic [7:0] a);
		u_master.send_byte(8'h0D);
		u_master.send_byte(8'h0A);
		u_master.send_byte(c);
		u_master.send_byte(a);
	endtask
	task automatic t_query(input int k, input logic [2:0] a, input logic pre,
		input logic ng, input logic [19:0] v, input int d);
		logic [7:0] e[14];
		int         n;
		sw = a;
		neg = ng;
		bcd = v;
		dly = d;
		exp_code = codes[k];
		u_master.rx_q.delete();
		if (pre)
			u_master.send_byte(8'h0D);
		send4(codes[k], 8'h30 + a);
		n = 0;
		while (u_master.rx_q.size() < 14 && n < 4000)
		begin
			tick(1);
			n++;
		end
		e = '{8'h0D, 8'h0A, codes[k], 8'h30 + a, 8'h3D, ng ? 8'h2D : 8'h2B, 8'h30 + v[19:16],
			8'h30 + v[15:12], 8'h30 + v[11:8], 8'h30 + v[7:4], 8'h2E, 8'h30 + v[3:0],
			units[k], 8'h21};
		for (int i = 0; i < 14; i++)
			cmp(u_master.rx_q[i], e[i]);
		tick(2 * BITC);
		cmp(8'(u_master.rx_q.size()), 8'h0E);
	endtask
	task automatic t_silent(input logic [7:0] c, input logic [7:0] a);
		u_master.rx_q.delete();
		send4(c, a);
		tick(400);
		cmp(8'(u_master.rx_q.size()), 8'h00);
		cmp({7'h00, req}, 8'h00);
	endtask
	task automatic t_contact;
		logic [15:0] vs[3];
		vs = '{16'h028A, 16'h028B, 16'h0000};
		for (int i = 0; i < 3; i++)
		begin
			batt = vs[i];
			tick(2);
			cmp({7'h00, contact}, {7'h00, vs[i] > 16'h028A});
		end
	endtask
	task automatic t_inhibit;
		sa = 1'b1;
		topen = 1'b1;
		rst_b = 1'b0;
		tick(2);
		rst_b = 1'b1;
		tick(20);
		cmp({7'h00, run_en}, 8'h00);
		topen = 1'b0;
		tick(10);
		cmp({7'h00, run_en}, 8'h01);
		sa = 1'b0;
	endtask
	initial
	begin
		tick(3);
		rst_b = 1'b1;
		tick(10);
		cmp({7'h00, run_en}, 8'h01);
		for (int k = 0; k < 8; k++)
			t_query(k, 3'h0, 1'b0, k[0], 20'h12340 + 20'(k), k);
		t_query(7, 3'h4, 1'b1, 1'b1, 20'h98769, 3);
		t_query(2, 3'h3, 1'b0, 1'b0, 20'h05500, 1);
		t_silent(8'h56, 8'h34);
		t_silent(8'h58, 8'h33);
		t_contact();
		t_inhibit();
		give_verdict();
	end
endmodule
